// ==== core/psm_map.svh ====
// constants of the power saving mode controller
// assumes inclusion by bare name from the design file only
`ifndef PSM_MAP_SVH
`define PSM_MAP_SVH

// master clock rate and cycle counts
`define PSM_CLK_HZ          20000000
`define PSM_STARTUP_SHORT   13'h0100
`define PSM_STARTUP_LONG    13'h1000
`define PSM_STARTUP_W       13

// slow divider: field value n divides by 2^(n+1)
`define PSM_DIV_W           4
`define PSM_DIV_ONE         4'h1

// interrupt mask forced on wait and halt entry
`define PSM_MASK_ENABLE_ALL 2'b10

// auto-wake timing, in rc oscillator periods
`define PSM_AWU_FIXED_DIV   6'h3f
`define PSM_RC_START_TICKS  4'h8
`define PSM_PRESCALER_NONE  8'h00
`define PSM_PRESCALER_ONE   8'h01

`endif

// ==== core/psm_pkg.sv ====
// types of the power saving mode controller
// uses nothing from psm_map.svh
package psm_pkg;

    typedef enum logic [2:0] {
        PSM_RUN,
        PSM_WAIT,
        PSM_HALT,
        PSM_ACT_HALT,
        PSM_AWU_HALT,
        PSM_STARTUP
    } psm_state_type;

    // clock gating outputs towards cpu, peripherals and oscillators
    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic osc_enable;
        logic timebase_run;
        logic rc_osc_enable;
    } psm_clk_ctrl_type;

    // software visible auto-wake status
    typedef struct packed {
        logic auto_wake_flag;
        logic auto_wake_irq;
    } psm_awu_stat_type;

endpackage

// ==== core/psm_power_ctrl.sv ====
// power saving mode controller: slow, wait, halt, active halt, auto-wake halt
// assumes single-cycle instruction strobes and interrupt levels from logic on clk;
// the rc oscillator output arrives from its own clock and is synchronised here
//
// Overview of operation
// - slow select bit plus two-bit divider field
// - slow clocks cpu and peripherals divided
// - wait during slow keeps divided clock
// - wait stops cpu, peripherals keep running
// - wait entry forces interrupt mask to 10
// - wait ends on interrupt or reset
// - halt with both enables clear: plain halt
// - halt with timebase enable: active halt
// - halt with only auto-wake enable: auto-wake halt
// - halt exit restarts oscillator, 256/4096 delay
// - halt entry forces mask; pending interrupt wakes
// - plain halt stops oscillator and processing
// - watchdog option decides reset on halt
// - active halt keeps oscillator and timebase only
// - active halt reset exit delayed, interrupt not
// - active halt never causes watchdog reset
// - active halt exits on timebase, interrupt, reset
// - auto-wake starts rc, fixed plus prescaler divide
// - elapsed delay sets flag, interrupt, restarts oscillator
// - status read clears flag and interrupt
// - measure bit routes rc to capture one
// - auto-wake halt exits on interrupt or reset
// - delay is 8 start-up plus 64 times prescaler rc periods
// - prescaler used directly; zero is forbidden, the code wakes at once on zero
`timescale 1ns/1ps
`include "psm_map.svh"

module psm_power_ctrl (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      slow_select_bit,
    input  wire logic [1:0]                slow_divider_field,
    input  wire logic                      wait_for_interrupt_instr,
    input  wire logic                      halt_instr,
    input  wire logic                      timebase_interrupt_enable,
    input  wire logic                      auto_wake_enable,
    input  wire logic                      auto_wake_measure,
    input  wire logic [7:0]                auto_wake_prescaler,
    input  wire logic                      watchdog_enabled,
    input  wire logic                      watchdog_halt_option,
    input  wire logic                      long_startup_option,
    input  wire logic                      irq_pending,
    input  wire logic                      halt_wake_irq,
    input  wire logic                      timebase_irq,
    input  wire logic                      status_read,
    input  wire logic                      rc_osc_clk,
    output psm_pkg::psm_clk_ctrl_type      clk_ctrl,
    output psm_pkg::psm_awu_stat_type      awu_stat,
    output logic                           mask_force,
    output logic [1:0]                     mask_value,
    output logic                           watchdog_reset_req,
    output logic                           slow_wait_active,
    output logic                           timer_capture_input_one,
    output psm_pkg::psm_state_type         power_state
);

    psm_pkg::psm_state_type      state_q;
    psm_pkg::psm_state_type      state_d;
    logic [`PSM_DIV_W-1:0]       div_cnt_q;
    logic [`PSM_DIV_W-1:0]       div_lim;
    logic [1:0]                  div_sel_q;
    logic                        slow_q;
    logic                        tick_q;
    logic                        div_wrap;
    logic [`PSM_STARTUP_W-1:0]   start_cnt_q;
    logic [`PSM_STARTUP_W-1:0]   start_lim;
    logic                        rc_s1_q;
    logic                        rc_s2_q;
    logic                        rc_s3_q;
    logic                        rc_rise;
    logic                        rc_run;
    logic                        fixed_wrap;
    logic [3:0]                  rc_start_q;
    logic [5:0]                  fixed_cnt_q;
    logic [7:0]                  pre_cnt_q;
    logic                        awu_elapse;
    logic                        flag_q;
    logic                        mask_force_q;
    logic                        wdg_rst_q;
    logic                        cap_q;
    logic                        halt_ok;

    // ************************************************************
    // slow clock divider
    // ************************************************************

    // selection only changes at a divided-clock boundary
    always_comb begin
        div_lim = `PSM_DIV_ONE;
        if (slow_q) begin
            // three-bit shift amount so code 3 reaches divide-by-16
            div_lim = `PSM_DIV_W'((`PSM_DIV_ONE << ({1'b0, div_sel_q} + 3'h1))
                                  - `PSM_DIV_ONE);
        end
    end

    assign div_wrap = (div_cnt_q >= div_lim) || !slow_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt_q <= '0;
        end else if (div_wrap) begin
            div_cnt_q <= '0;
        end else begin
            div_cnt_q <= div_cnt_q + `PSM_DIV_ONE;
        end
    end

    // one-cycle enable at every divided-clock boundary
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= div_wrap;
        end
    end

    // mode and divider taken only at a boundary, so no short cpu period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slow_q    <= 1'b0;
            div_sel_q <= 2'h0;
        end else if (div_wrap) begin
            slow_q    <= slow_select_bit;
            div_sel_q <= slow_divider_field;
        end
    end

    // ************************************************************
    // mode sequencing
    // ************************************************************

    // active halt never triggers the watchdog; others follow the option
    assign halt_ok = timebase_interrupt_enable || !watchdog_enabled || watchdog_halt_option;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            psm_pkg::PSM_RUN: begin
                // wait is taken before halt when both strobes arrive together
                if (wait_for_interrupt_instr) begin
                    state_d = psm_pkg::PSM_WAIT;
                end else if (halt_instr && halt_ok) begin
                    if (timebase_interrupt_enable) begin
                        state_d = psm_pkg::PSM_ACT_HALT;
                    end else if (auto_wake_enable) begin
                        state_d = psm_pkg::PSM_AWU_HALT;
                    end else begin
                        state_d = psm_pkg::PSM_HALT;
                    end
                end
            end
            psm_pkg::PSM_WAIT: begin
                if (irq_pending) begin
                    state_d = psm_pkg::PSM_RUN;
                end
            end
            psm_pkg::PSM_HALT: begin
                if (halt_wake_irq) begin
                    state_d = psm_pkg::PSM_STARTUP;
                end
            end
            psm_pkg::PSM_ACT_HALT: begin
                // interrupt exits skip the start-up delay
                if (timebase_irq || halt_wake_irq) begin
                    state_d = psm_pkg::PSM_RUN;
                end
            end
            psm_pkg::PSM_AWU_HALT: begin
                if (awu_elapse || halt_wake_irq) begin
                    state_d = psm_pkg::PSM_STARTUP;
                end
            end
            psm_pkg::PSM_STARTUP: begin
                if (start_cnt_q >= start_lim) begin
                    state_d = psm_pkg::PSM_RUN;
                end
            end
        endcase
    end

    // reset lands in startup so every reset exit waits for the oscillator
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= psm_pkg::PSM_STARTUP;
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // oscillator start-up delay
    // ************************************************************

    assign start_lim = long_startup_option ? `PSM_STARTUP_LONG : `PSM_STARTUP_SHORT;

    // reset loads the same count as a wake-up, so both wait equally long
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_cnt_q <= `PSM_STARTUP_W'(1);
        end else if (state_q == psm_pkg::PSM_STARTUP) begin
            start_cnt_q <= start_cnt_q + `PSM_STARTUP_W'(1);
        end else begin
            start_cnt_q <= `PSM_STARTUP_W'(1);
        end
    end

    // ************************************************************
    // interrupt mask forcing and watchdog
    // ************************************************************

    // pulses in the first cycle of wait or of any halt
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_force_q <= 1'b0;
        end else begin
            mask_force_q <= (state_q == psm_pkg::PSM_RUN) && (state_d != psm_pkg::PSM_RUN);
        end
    end

    // a refused halt leaves the mode alone and asks for a reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdg_rst_q <= 1'b0;
        end else begin
            wdg_rst_q <= (state_q == psm_pkg::PSM_RUN) && !wait_for_interrupt_instr
                         && halt_instr && !halt_ok;
        end
    end

    // ************************************************************
    // rc oscillator and auto-wake delay
    // ************************************************************

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
        end else begin
            rc_s1_q <= rc_osc_clk;
            rc_s2_q <= rc_s1_q;
        end
    end

    // previous synchronised level, for edge detection only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rc_s3_q <= 1'b0;
        end else begin
            rc_s3_q <= rc_s2_q;
        end
    end

    assign rc_rise = rc_s2_q && !rc_s3_q;

    // start-up ticks, then 64 per prescaler step; zero prescaler wakes at once
    assign rc_run     = rc_rise && (rc_start_q == `PSM_RC_START_TICKS);
    assign fixed_wrap = rc_run && (fixed_cnt_q == `PSM_AWU_FIXED_DIV);
    assign awu_elapse = (state_q == psm_pkg::PSM_AWU_HALT)
                        && ((auto_wake_prescaler == `PSM_PRESCALER_NONE)
                            || (fixed_wrap && pre_cnt_q == auto_wake_prescaler));

    // rc start-up ticks before the divider chain counts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rc_start_q <= 4'h0;
        end else if (state_q != psm_pkg::PSM_AWU_HALT) begin
            rc_start_q <= 4'h0;
        end else if (rc_rise && rc_start_q != `PSM_RC_START_TICKS) begin
            rc_start_q <= rc_start_q + 4'h1;
        end
    end

    // fixed divide by 64 of the rc clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fixed_cnt_q <= 6'h00;
        end else if (state_q != psm_pkg::PSM_AWU_HALT || fixed_wrap) begin
            fixed_cnt_q <= 6'h00;
        end else if (rc_run) begin
            fixed_cnt_q <= fixed_cnt_q + 6'h01;
        end
    end

    // programmable prescaler, stepped once per fixed-divider wrap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_cnt_q <= `PSM_PRESCALER_ONE;
        end else if (state_q != psm_pkg::PSM_AWU_HALT) begin
            pre_cnt_q <= `PSM_PRESCALER_ONE;
        end else if (fixed_wrap) begin
            pre_cnt_q <= pre_cnt_q + `PSM_PRESCALER_ONE;
        end
    end

    // set wins over a clearing read in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (awu_elapse) begin
            flag_q <= 1'b1;
        end else if (status_read) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_q <= 1'b0;
        end else begin
            cap_q <= auto_wake_measure && (state_q == psm_pkg::PSM_RUN) && rc_s2_q;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************

    always_comb begin
        clk_ctrl.cpu_clk_en    = tick_q && (state_q == psm_pkg::PSM_RUN);
        clk_ctrl.periph_clk_en = tick_q && ((state_q == psm_pkg::PSM_RUN)
                                 || (state_q == psm_pkg::PSM_WAIT));
        clk_ctrl.osc_enable    = (state_q != psm_pkg::PSM_HALT)
                                 && (state_q != psm_pkg::PSM_AWU_HALT);
        clk_ctrl.timebase_run  = (state_q != psm_pkg::PSM_HALT)
                                 && (state_q != psm_pkg::PSM_AWU_HALT);
        clk_ctrl.rc_osc_enable = (state_q == psm_pkg::PSM_AWU_HALT)
                                 || (auto_wake_measure && state_q == psm_pkg::PSM_RUN);
    end

    assign awu_stat.auto_wake_flag = flag_q;
    assign awu_stat.auto_wake_irq  = flag_q;
    assign mask_force              = mask_force_q;
    assign mask_value              = `PSM_MASK_ENABLE_ALL;
    assign watchdog_reset_req      = wdg_rst_q;
    assign slow_wait_active        = slow_q && (state_q == psm_pkg::PSM_WAIT);
    assign timer_capture_input_one = cap_q;
    assign power_state             = state_q;

endmodule

// ==== verif/psm_power_ctrl_assertions.sv ====
// concurrent checks of the power saving mode controller
// assumes binding onto psm_power_ctrl, one clock domain
`timescale 1ns/1ps
module psm_power_ctrl_assertions (
    input wire logic                      clk,
    input wire logic                      rst,
    input wire logic                      wait_for_interrupt_instr,
    input wire logic                      halt_instr,
    input wire logic                      timebase_interrupt_enable,
    input wire logic                      auto_wake_enable,
    input wire logic                      watchdog_enabled,
    input wire logic                      watchdog_halt_option,
    input wire logic                      halt_wake_irq,
    input wire logic                      timebase_irq,
    input wire logic                      status_read,
    input wire psm_pkg::psm_clk_ctrl_type clk_ctrl,
    input wire psm_pkg::psm_awu_stat_type awu_stat,
    input wire logic                      mask_force,
    input wire logic                      watchdog_reset_req,
    input wire psm_pkg::psm_state_type    power_state
);
    // ****************
    // mode checks
    // ****************
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst);
    logic run, hlt, refuse, in_halt, in_act, in_awu;
    assign run = power_state == psm_pkg::PSM_RUN;
    assign in_halt = power_state == psm_pkg::PSM_HALT;
    assign in_act = power_state == psm_pkg::PSM_ACT_HALT;
    assign in_awu = power_state == psm_pkg::PSM_AWU_HALT;
    assign hlt = run && halt_instr && !wait_for_interrupt_instr;
    assign refuse = !timebase_interrupt_enable && watchdog_enabled && !watchdog_halt_option;
    property p_wait; run && wait_for_interrupt_instr |=> !run && mask_force; endproperty
    a_wait: assert property (p_wait) else $error("wait entry wrong");
    property p_plain;
        hlt && !timebase_interrupt_enable && !auto_wake_enable && !refuse |=> in_halt;
    endproperty
    a_plain: assert property (p_plain) else $error("plain halt wrong");
    property p_act; hlt && timebase_interrupt_enable |=> in_act && mask_force; endproperty
    a_act: assert property (p_act) else $error("active halt wrong");
    property p_awu;
        hlt && !timebase_interrupt_enable && auto_wake_enable && !refuse |=> in_awu;
    endproperty
    a_awu: assert property (p_awu) else $error("auto-wake halt wrong");
    property p_refuse; hlt && refuse |=> run ##[0:1] watchdog_reset_req; endproperty
    a_refuse: assert property (p_refuse) else $error("watchdog reset missing");
    property p_no_wdr; hlt && !refuse |=> !watchdog_reset_req [*2]; endproperty
    a_no_wdr: assert property (p_no_wdr) else $error("spurious watchdog reset");
    property p_off; in_halt || in_awu |-> !clk_ctrl.osc_enable && !clk_ctrl.cpu_clk_en; endproperty
    a_off: assert property (p_off) else $error("oscillator on in halt");
    property p_act_clk;
        in_act |-> clk_ctrl.timebase_run && !clk_ctrl.periph_clk_en && !clk_ctrl.cpu_clk_en;
    endproperty
    a_act_clk: assert property (p_act_clk) else $error("active halt clocks wrong");
    property p_act_out; in_act && (timebase_irq || halt_wake_irq) |=> run; endproperty
    a_act_out: assert property (p_act_out) else $error("active halt exit delayed");
    property p_halt_out; in_halt && halt_wake_irq |=> clk_ctrl.osc_enable && !run; endproperty
    a_halt_out: assert property (p_halt_out) else $error("halt exit wrong");
    property p_clear;
        run && status_read |=> !awu_stat.auto_wake_flag && !awu_stat.auto_wake_irq;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");
    c_act: cover property (in_act ##1 run);
    c_awu: cover property (in_awu ##1 awu_stat.auto_wake_flag);
    c_wdr: cover property (watchdog_reset_req);
endmodule

// ==== verif/psm_rc_model.sv ====
// model of the rc wake-up oscillator beside the controller
// assumes its enable comes from the controller's clock outputs
`timescale 1ns/1ps
module psm_rc_model #(
    parameter int HALF_NS = 200,
    parameter int SKEW_NS = 7
) (
    input  wire logic rc_osc_enable,
    output logic      rc_osc_clk
);
    // runs only while enabled, stands low otherwise; the skew keeps its
    // edges off the controller's clock edges
    initial begin
        rc_osc_clk = 1'h0;
        forever begin
            wait (rc_osc_enable === 1'h1);
            #(SKEW_NS);
            while (rc_osc_enable === 1'h1) begin
                #(HALF_NS) rc_osc_clk = 1'h1;
                #(HALF_NS) rc_osc_clk = 1'h0;
            end
        end
    end
endmodule

// ==== verif/psm_power_ctrl_tb.sv ====
// testbench of the power saving mode controller
// assumes the controller, its package and the rc oscillator model
`timescale 1ns/1ps
module psm_power_ctrl_tb;
    typedef struct packed {
        logic                   tie;
        logic                   awe;
        logic                   wd;
        logic                   opt;
        logic                   lng;
        psm_pkg::psm_state_type st;
    } psm_row_type;
    logic clk, rst, slow_select_bit, wait_for_interrupt_instr, halt_instr, auto_wake_measure;
    logic timebase_interrupt_enable, auto_wake_enable, watchdog_enabled, watchdog_halt_option;
    logic long_startup_option, irq_pending, halt_wake_irq, timebase_irq, status_read, wr;
    logic mask_force, watchdog_reset_req, slow_wait_active, timer_capture_input_one;
    logic [1:0] slow_divider_field, mask_value;
    logic [7:0] auto_wake_prescaler;
    wire        rc_osc_clk;
    psm_pkg::psm_clk_ctrl_type clk_ctrl;
    psm_pkg::psm_awu_stat_type awu_stat;
    psm_pkg::psm_state_type    power_state;
    int err_count, n_compared, cyc, n, c;
    psm_row_type rows [6] = '{
        '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, psm_pkg::PSM_HALT},
        '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1, psm_pkg::PSM_HALT},
        '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, psm_pkg::PSM_ACT_HALT},
        '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, psm_pkg::PSM_ACT_HALT},
        '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0, psm_pkg::PSM_AWU_HALT},
        '{1'h0, 1'h0, 1'h1, 1'h0, 1'h0, psm_pkg::PSM_RUN}
    };
    psm_power_ctrl dut (.*);
    psm_rc_model rc (.rc_osc_enable(clk_ctrl.rc_osc_enable), .rc_osc_clk(rc_osc_clk));
    // ****************
    // helpers
    // ****************
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_st(input string nm, input psm_pkg::psm_state_type e, g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    // waits for a mode and checks the time it took against a window
    task automatic wait_st(input psm_pkg::psm_state_type s, input int e);
        c = 0;
        while (power_state !== s && c < 6000) begin
            step(1);
            c++;
        end
        chk_bit("delay", 1'h1, c >= e - 4 && c <= e + 12);
    endtask
    task automatic count(input int k);
        n = 0;
        c = 0;
        repeat (k) begin
            step(1);
            n += clk_ctrl.cpu_clk_en;
            c += clk_ctrl.periph_clk_en;
        end
    endtask
    task automatic end_sim;
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ****************
    // stimulus
    // ****************
    initial begin
        {slow_select_bit, wait_for_interrupt_instr, halt_instr, auto_wake_measure} = 4'h0;
        {timebase_interrupt_enable, auto_wake_enable, watchdog_enabled} = 3'h0;
        {watchdog_halt_option, long_startup_option, irq_pending} = 3'h0;
        {halt_wake_irq, timebase_irq, status_read} = 3'h0;
        slow_divider_field = 2'h0;
        auto_wake_prescaler = 8'h02;
        rst = 1'h1;
        step(16);
        rst = 1'h0;
        wait_st(psm_pkg::PSM_RUN, 256);
        for (int i = 0; i < 6; i++) begin
            {timebase_interrupt_enable, auto_wake_enable} = {rows[i].tie, rows[i].awe};
            {watchdog_enabled, watchdog_halt_option} = {rows[i].wd, rows[i].opt};
            long_startup_option = rows[i].lng;
            step(2);
            halt_instr = 1'h1;
            step(1);
            halt_instr = 1'h0;
            chk_st("mode", rows[i].st, power_state);
            chk_bit("mask", rows[i].st != psm_pkg::PSM_RUN, mask_force);
            wr = watchdog_reset_req;
            step(1);
            chk_bit("wdog", rows[i].st == psm_pkg::PSM_RUN, wr && !watchdog_reset_req);
            halt_wake_irq = rows[i].st == psm_pkg::PSM_HALT;
            timebase_irq = rows[i].st == psm_pkg::PSM_ACT_HALT;
            if (rows[i].st == psm_pkg::PSM_AWU_HALT) begin
                wait_st(psm_pkg::PSM_STARTUP, 1085);
                chk_bit("flag", 1'h1, awu_stat.auto_wake_flag);
            end
            step(1);
            {halt_wake_irq, timebase_irq} = 2'h0;
            if (rows[i].st == psm_pkg::PSM_ACT_HALT)
                chk_st("wake", psm_pkg::PSM_RUN, power_state);
            else if (rows[i].st != psm_pkg::PSM_RUN)
                wait_st(psm_pkg::PSM_RUN, rows[i].lng ? 4095 : 255);
        end
        status_read = 1'h1;
        step(1);
        status_read = 1'h0;
        chk_bit("flag", 1'h0, awu_stat.auto_wake_flag);
        slow_select_bit = 1'h1;
        slow_divider_field = 2'h1;
        step(40);
        {wait_for_interrupt_instr, halt_instr} = 2'h3;
        step(1);
        {wait_for_interrupt_instr, halt_instr} = 2'h0;
        chk_st("mode", psm_pkg::PSM_WAIT, power_state);
        chk_bit("mask", 1'h1, mask_force && mask_value === 2'h2);
        step(1);
        chk_bit("slow", 1'h1, slow_wait_active);
        count(16);
        chk_bit("cpu", 1'h1, n == 0 && c == 4);
        irq_pending = 1'h1;
        step(1);
        irq_pending = 1'h0;
        chk_st("wake", psm_pkg::PSM_RUN, power_state);
        for (int i = 0; i < 5; i++) begin
            slow_select_bit = i < 4;
            slow_divider_field = i[1:0];
            step(40);
            count(64);
            chk_bit("div", 1'h1, n == (i < 4 ? 32 >> i : 64) && c == n);
        end
        auto_wake_measure = 1'h1;
        step(4);
        chk_bit("rc", 1'h1, clk_ctrl.rc_osc_enable);
        n = 0;
        repeat (64) begin
            wr = timer_capture_input_one;
            step(1);
            n += wr != timer_capture_input_one;
        end
        chk_bit("capture", 1'h1, n >= 8);
        auto_wake_measure = 1'h0;
        timebase_interrupt_enable = 1'h1;
        halt_instr = 1'h1;
        step(1);
        halt_instr = 1'h0;
        chk_st("mode", psm_pkg::PSM_ACT_HALT, power_state);
        rst = 1'h1;
        step(2);
        rst = 1'h0;
        chk_st("reset", psm_pkg::PSM_STARTUP, power_state);
        wait_st(psm_pkg::PSM_RUN, 256);
        end_sim();
    end
endmodule
bind psm_power_ctrl psm_power_ctrl_assertions chk (.*);
